// ==== led_drv_defs.svh ====
// Purpose: shared constants of the serial LED sink driver control
// Assumes: 10 MHz reference clock
// Notes:   timing counts are derived from times, never typed as cycles
`ifndef LED_DRV_DEFS_SVH
`define LED_DRV_DEFS_SVH

`define CHAN_COUNT      16
`define CODE_WIDTH      6
`define CODE_RESET      6'h1f
`define CLK_PERIOD_NS   100
`define OPEN_DET_NS     200
// least time, so round up, and never below one cycle
`define OPEN_DET_CYC    (((`OPEN_DET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                         ((`OPEN_DET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define SYNC_STAGES     3
`define BUF_DATA_BIT    0
`define BUF_PATH_BIT    1
`define BUF_WIDTH       2

`endif

// ==== led_drv_pkg.sv ====
// Purpose: types of the serial LED sink driver control
// Assumes: constants live in led_drv_defs.svh
// Notes:   none
`include "led_drv_defs.svh"
package led_drv_pkg;
  typedef logic [`CODE_WIDTH-1:0] code_t;
  typedef logic [`CHAN_COUNT-1:0] chan_word_t;
endpackage

// ==== bit_buffer.sv ====
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   in_ready falls only when both entries are full
`timescale 1ns/1ns
`default_nettype none
module bit_buffer #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] head_r;
  logic [WIDTH-1:0] tail_r;
  logic [1:0]       count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != 2'h2);
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o  = head_r;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // occupancy
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      count_r <= 2'h0;
    end else if (push && !pop) begin
      count_r <= count_r + 2'h1;
    end else if (pop && !push) begin
      count_r <= count_r - 2'h1;
    end
  end

  // head is the oldest word; tail only used when both are full
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      head_r <= '0;
      tail_r <= '0;
    end else begin
      if (pop) begin
        head_r <= (count_r == 2'h2) ? tail_r : in_data_i;
      end else if (push && count_r == 2'h0) begin
        head_r <= in_data_i;
      end
      if (push && ((count_r == 2'h1 && !pop) || (count_r == 2'h2))) begin
        tail_r <= in_data_i;
      end
    end
  end
endmodule
`default_nettype wire

// ==== led_sink_ctrl.sv ====
// Purpose: digital control of a 16-channel constant-current LED sink driver
// Assumes: all pins arrive asynchronously to REF_CLK_I (10 MHz); the serial
//          clock is sampled, so it must stay well below a quarter of REF_CLK_I
// Notes:   fault pin is open drain: FAULT_O low, FAULT_OE_O high pulls it low
// Notes on behaviour
// (RL1) path select low: serial bits fill the 6-bit current code, MSB first
// (RL2) channel current is base current times code divided by 64
// (RL3) active current code holds until a new shifted code is latched
// (RL4) current code resets to 011111, about half the base current
// (RL5) path select high: serial bits shift into the 16-bit channel register
// (RL6) latched channel bit 1 turns its output on, 0 turns it off
// (RL7) channel latch passes through while strobe high, holds while low
// (RL8) serial out changes on falling clock if edge select high, else rising
// (RL9) fault pin pulled low when overtemperature above 150 C is reported
// (RL10) thermal fault releases only below 100 C or after a power cycle
// (RL11) fault pin is the OR of thermal fault and open-LED fault
// (RL12) enable high turns all outputs off and suppresses open-LED detection
// (RL13) open-LED fault when an on channel reads below 0.3 V
// (RL14) open-LED detection waits 0.2 us after a channel turns on
// (RL15) controller disables outputs and watches fault to tell open from hot
// (RL16) controller shifts 32 ones through a cascade, latches, enables
// (RL17) controller walks a single one through 31 zeros watching the fault
// (RL18) controller latches the code before raising path select for data
// (RL19) strobe with path select low loads the code, channel latch untouched
// (RL20) serial out comes from the last channel shift stage for cascading
`timescale 1ns/1ns
`default_nettype none
`include "led_drv_defs.svh"
module led_sink_ctrl #(
  parameter int CHANNELS = `CHAN_COUNT
) (
  // clock and reset
  input  wire logic                REF_CLK_I,
  input  wire logic                RESET_N_I,
  // serial stream pins
  input  wire logic                SERIAL_CLK_I,
  input  wire logic                SERIAL_IN_I,
  input  wire logic                PATH_SELECT_I,
  input  wire logic                LATCH_I,
  input  wire logic                OUT_EDGE_SELECT_I,
  output logic                     SERIAL_OUT_O,
  // channel control
  input  wire logic                ENABLE_N_I,
  input  wire logic [CHANNELS-1:0] CHANNEL_LOW_I,
  output logic      [CHANNELS-1:0] CHANNEL_CURRENT_OUT_O,
  output var led_drv_pkg::code_t   CURRENT_CODE_O,
  // thermal sensor levels
  input  wire logic                OVERTEMP_I,
  input  wire logic                COOLED_I,
  // fault pin, open drain
  output logic                     FAULT_O,
  output logic                     FAULT_OE_O,
  // stream status
  output logic                     STREAM_OVERRUN_O
);
  import led_drv_pkg::*;

  localparam int SYN_W = CHANNELS + 8;
  localparam int CNT_W = $clog2(`OPEN_DET_CYC + 1);
  localparam logic [CNT_W-1:0] DET_CYC = CNT_W'(`OPEN_DET_CYC);

  // synchroniser stages
  logic [SYN_W-1:0] sync1_r;
  logic [SYN_W-1:0] sync2_r;
  logic [SYN_W-1:0] sync3_r;
  logic [SYN_W-1:0] filt_r;
  logic [SYN_W-1:0] pins;
  // filtered pin levels
  logic             sclk_s;
  logic             sdin_s;
  logic             path_s;
  logic             latch_s;
  logic             oes_s;
  logic             en_off_s;
  logic             hot_s;
  logic             cool_s;
  logic [CHANNELS-1:0] low_s;
  // edges and stream
  logic             sclk_q_r;
  logic             latch_q_r;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             push_ready;
  logic             pop_valid;
  logic             pop_ready;
  logic [`BUF_WIDTH-1:0] pop_data;
  logic             pop;
  // shift and latch state
  code_t            code_sh_r;
  code_t            code_act_r;
  logic [CHANNELS-1:0] chan_sh_r;
  logic [CHANNELS-1:0] chan_lat_r;
  // fault state
  logic             therm_r;
  logic [CHANNELS-1:0] open_r;
  logic [CHANNELS-1:0] on_now;

  assign pins = {COOLED_I, OVERTEMP_I, ENABLE_N_I, OUT_EDGE_SELECT_I, LATCH_I,
                 PATH_SELECT_I, SERIAL_IN_I, SERIAL_CLK_I, CHANNEL_LOW_I};

  // three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // filter: keep the old level while the last two stages disagree
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      filt_r <= '0;
    end else begin
      for (int i = 0; i < SYN_W; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          filt_r[i] <= sync3_r[i];
        end
      end
    end
  end

  assign low_s    = filt_r[CHANNELS-1:0];
  assign sclk_s   = filt_r[CHANNELS];
  assign sdin_s   = filt_r[CHANNELS+1];
  assign path_s   = filt_r[CHANNELS+2];
  assign latch_s  = filt_r[CHANNELS+3];
  assign oes_s    = filt_r[CHANNELS+4];
  assign en_off_s = filt_r[CHANNELS+5];
  assign hot_s    = filt_r[CHANNELS+6];
  assign cool_s   = filt_r[CHANNELS+7];

  // edge history of serial clock and strobe
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      sclk_q_r  <= 1'b0;
      latch_q_r <= 1'b0;
    end else begin
      sclk_q_r  <= sclk_s;
      latch_q_r <= latch_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_q_r;
  assign sclk_fall = !sclk_s && sclk_q_r;

  // shift engine pauses one cycle as the strobe rises so the latch copy is settled
  assign pop_ready = !(latch_s && !latch_q_r);
  assign pop       = pop_valid && pop_ready;

  // each rising serial clock carries one bit plus the path it belongs to
  bit_buffer #(
    .WIDTH (`BUF_WIDTH)
  ) u_bit_buffer (
    .clk_i       (REF_CLK_I),
    .reset_n_i   (RESET_N_I),
    .in_valid_i  (sclk_rise),
    .in_ready_o  (push_ready),
    .in_data_i   ({path_s, sdin_s}),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  // sticky overrun: a serial clock too fast for the reference clock
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      STREAM_OVERRUN_O <= 1'b0;
    end else if (sclk_rise && !push_ready) begin
      STREAM_OVERRUN_O <= 1'b1;
    end
  end

  // current code shift register, MSB arrives first
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      code_sh_r <= `CODE_RESET;
    end else if (pop && !pop_data[`BUF_PATH_BIT]) begin
      code_sh_r <= {code_sh_r[`CODE_WIDTH-2:0], pop_data[`BUF_DATA_BIT]}; // [RL1]
    end
  end

  // active code: holds between strobes, loaded only by a strobe with path low
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      code_act_r <= `CODE_RESET; // [RL4]
    end else if (latch_s && !path_s) begin
      code_act_r <= code_sh_r; // [RL3] [RL19]
    end
  end

  // the analog stage scales base current by this code over 64
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      CURRENT_CODE_O <= `CODE_RESET;
    end else begin
      CURRENT_CODE_O <= code_act_r; // [RL2]
    end
  end

  // channel shift register
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      chan_sh_r <= '0;
    end else if (pop && pop_data[`BUF_PATH_BIT]) begin
      chan_sh_r <= {chan_sh_r[CHANNELS-2:0], pop_data[`BUF_DATA_BIT]}; // [RL5]
    end
  end

  // channel latch is transparent while the strobe is high on the channel path
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      chan_lat_r <= '0;
    end else if (latch_s && path_s) begin
      chan_lat_r <= chan_sh_r; // [RL7]
    end
  end

  // serial out follows the last stage on the selected serial clock edge
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      SERIAL_OUT_O <= 1'b0;
    end else if (oes_s ? sclk_fall : sclk_rise) begin
      SERIAL_OUT_O <= chan_sh_r[CHANNELS-1]; // [RL8] [RL20]
    end
  end

  // outputs on per latched bit, all off while enable is high
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      CHANNEL_CURRENT_OUT_O <= '0;
    end else begin
      CHANNEL_CURRENT_OUT_O <= en_off_s ? '0 : chan_lat_r; // [RL6] [RL12]
    end
  end

  assign on_now = CHANNEL_CURRENT_OUT_O;

  // open-LED detection per channel after the settling time
  for (genvar g = 0; g < CHANNELS; g++) begin : g_open
    logic [CNT_W-1:0] on_cnt_r;

    // count how long the channel has been on, saturating
    always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
        on_cnt_r <= '0;
      end else if (!on_now[g]) begin
        on_cnt_r <= '0;
      end else if (on_cnt_r != DET_CYC) begin
        on_cnt_r <= on_cnt_r + CNT_W'(1);
      end
    end

    // fault only from a channel settled on with output below threshold
    always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
        open_r[g] <= 1'b0;
      end else begin
        open_r[g] <= !en_off_s && on_now[g] && (on_cnt_r == DET_CYC) // [RL14]
                     && low_s[g]; // [RL13] [RL12]
      end
    end
  end

  // thermal flag with hysteresis; set wins over clear, reset is the power cycle
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      therm_r <= 1'b0;
    end else if (hot_s) begin
      therm_r <= 1'b1; // [RL9]
    end else if (cool_s) begin
      therm_r <= 1'b0; // [RL10]
    end
  end

  // open drain: data always low, enable pulls the line
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      FAULT_O    <= 1'b0;
      FAULT_OE_O <= 1'b0;
    end else begin
      FAULT_O    <= 1'b0;
      FAULT_OE_O <= therm_r || (|open_r); // [RL11]
    end
  end

  // checks
  code_reset_a: assert property (@(posedge REF_CLK_I) // [RL4]
    $rose(RESET_N_I) |-> code_act_r == `CODE_RESET)
    else $error("current code not at reset pattern");
  code_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL3]
    !(latch_s && !path_s) |=> $stable(code_act_r))
    else $error("current code changed without strobe");
  code_load_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL19]
    (latch_s && !path_s) |=> code_act_r == $past(code_sh_r) && $stable(chan_lat_r))
    else $error("code strobe misbehaved");
  code_shift_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL1]
    (pop && !pop_data[1]) |=> code_sh_r[0] == $past(pop_data[0])
      && code_sh_r[5:1] == $past(code_sh_r[4:0]))
    else $error("code shift wrong");
  chan_shift_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL5]
    (pop && pop_data[1]) |=> chan_sh_r == {$past(chan_sh_r[CHANNELS-2:0]), $past(pop_data[0])})
    else $error("channel shift wrong");
  chan_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL7]
    !latch_s |=> $stable(chan_lat_r))
    else $error("channel latch moved while closed");
  out_off_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL12]
    en_off_s |=> CHANNEL_CURRENT_OUT_O == '0 ##1 open_r == '0)
    else $error("outputs or detection active while disabled");
  out_map_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL6]
    !en_off_s |=> CHANNEL_CURRENT_OUT_O == $past(chan_lat_r))
    else $error("output does not follow latch");
  sout_edge_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL8]
    $changed(SERIAL_OUT_O) |-> $past(oes_s ? sclk_fall : sclk_rise))
    else $error("serial out changed on wrong edge");
  therm_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL10]
    (therm_r && !cool_s) |=> therm_r ##1 FAULT_OE_O)
    else $error("thermal fault released early");
  fault_hot_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL9]
    hot_s |=> ##1 (FAULT_OE_O && !FAULT_O))
    else $error("fault not pulled low on overtemperature");
  open_wait_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL14]
    $rose(on_now[0]) |-> !open_r[0] [*2])
    else $error("open fault before settling time");
  fault_or_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // [RL11]
    (!therm_r && open_r == '0) |=> !FAULT_OE_O)
    else $error("fault pulled with no cause");

  code_load_c: cover property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    latch_s && !path_s && code_sh_r != code_act_r);
  chan_load_c: cover property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    latch_s && path_s && chan_sh_r != '0);
  thermal_c: cover property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    $fell(therm_r));
  open_c: cover property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    $rose(open_r[0]));
endmodule
`default_nettype wire

// ==== led_ctrl_model.sv ====
// Purpose: behavioural display controller that feeds the serial pins
// Assumes: serial clock high six reference cycles, low twelve within a frame, inside the input filter
// Notes:   serial clock rests low between frames; data line shows no stale bit
`timescale 1ns/1ns
`default_nettype none
module led_ctrl_model (
  // reference clock
  input  wire logic clk_i,
  // serial pins
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      path_o,
  output logic      latch_o
);
  // quiet pins from time zero
  initial begin
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
    path_o  = 1'b0;
    latch_o = 1'b0;
  end
  // wait n edges, then move just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // data held six cycles each side of the rise, longer than the filter needs
  task automatic rise(input logic b);
    sdata_o = b;
    step(6);
    sclk_o = 1'b1;
    step(6);
  endtask
  task automatic fall();
    sclk_o = 1'b0;
    step(6);
  endtask
  // whole frame, most significant bit first
  task automatic send(input logic p, input logic [15:0] w, input int n);
    path_o = p;
    for (int i = n - 1; i >= 0; i--) begin
      rise(w[i]);
      fall();
    end
    sdata_o = ~sdata_o; // released line must not keep the last bit
  endtask
  // strobe only after the last shift settled, path held throughout
  task automatic strobe();
    step(6);
    latch_o = 1'b1;
    step(8);
    latch_o = 1'b0;
    step(8);
  endtask
endmodule
`default_nettype wire

// ==== led_sink_driver_serial_ctrl_tb_top.sv ====
// Purpose: self-checking bench of the serial LED sink driver control
// Assumes: 10 MHz reference clock, controller model on the serial pins
// Notes:   fault line level is worked out here from the open-drain pair
`timescale 1ns/1ns
`default_nettype none
module led_sink_driver_serial_ctrl_tb_top;
  import led_drv_pkg::*;
  logic       clk;
  logic       reset_n;
  logic       edge_sel;
  logic       enable_n;
  logic       overtemp;
  logic       cooled;
  chan_word_t chan_low;
  chan_word_t chan_out;
  code_t      code_out;
  logic       sclk;
  logic       sdata;
  logic       path;
  logic       latch;
  logic       serial_out;
  logic       fault_d;
  logic       fault_oe;
  logic       overrun;
  logic       fault_line;
  int         num_errors;
  int         num_checks;

  // pull-up on the shared fault line
  assign fault_line = fault_oe ? fault_d : 1'b1;

  // clock source
  initial clk = 1'b0;
  always #50 clk = ~clk;

  led_ctrl_model m (
    .clk_i   (clk),
    .sclk_o  (sclk),
    .sdata_o (sdata),
    .path_o  (path),
    .latch_o (latch)
  );

  led_sink_ctrl dut_u (
    .REF_CLK_I             (clk),
    .RESET_N_I             (reset_n),
    .SERIAL_CLK_I          (sclk),
    .SERIAL_IN_I           (sdata),
    .PATH_SELECT_I         (path),
    .LATCH_I               (latch),
    .OUT_EDGE_SELECT_I     (edge_sel),
    .SERIAL_OUT_O          (serial_out),
    .ENABLE_N_I            (enable_n),
    .CHANNEL_LOW_I         (chan_low),
    .CHANNEL_CURRENT_OUT_O (chan_out),
    .CURRENT_CODE_O        (code_out),
    .OVERTEMP_I            (overtemp),
    .COOLED_I              (cooled),
    .FAULT_O               (fault_d),
    .FAULT_OE_O            (fault_oe),
    .STREAM_OVERRUN_O      (overrun)
  );

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // bounded wait for a fault line level, then judge it
  task automatic wait_fault(input logic exp, input int lim);
    for (int i = 0; i < lim && fault_line !== exp; i++) step(1);
    check({15'h0000, fault_line}, {15'h0000, exp}, "fault line");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // values straight out of reset
  task automatic test_reset();
    check({10'h000, code_out}, 16'h001f, "reset code");
    check(chan_out, 16'h0000, "reset channels");
    check({15'h0000, fault_line}, 16'h0001, "reset fault");
  endtask

  // code path, then a channel frame that must not disturb the code
  task automatic test_code_and_chan();
    m.send(1'b0, 16'h0025, 6);
    m.strobe();
    check({10'h000, code_out}, 16'h0025, "code load");
    check(chan_out, 16'h0000, "channels kept on code strobe");
    m.send(1'b1, 16'haaaa, 16);
    check(chan_out, 16'h0000, "latch holds while low");
    m.strobe();
    check(chan_out, 16'haaaa, "channel word");
    check({10'h000, code_out}, 16'h0025, "code held");
  endtask

  // seventeenth bit shows the chain tail on the chosen edge
  task automatic test_sout(input logic es, input logic mid, input logic aft);
    edge_sel = es;
    m.send(1'b1, 16'haaaa, 16);
    m.rise(1'b0);
    check({15'h0000, serial_out}, {15'h0000, mid}, "serial out after rise");
    m.fall();
    check({15'h0000, serial_out}, {15'h0000, aft}, "serial out after fall");
    check(chan_out, 16'haaaa, "outputs untouched by shifting");
  endtask

  // thermal flag with hysteresis, not hidden by the enable
  task automatic test_thermal();
    overtemp = 1'b1;
    wait_fault(1'b0, 12);
    overtemp = 1'b0;
    step(20);
    check({15'h0000, fault_line}, 16'h0000, "thermal held");
    enable_n = 1'b1;
    step(12);
    check({15'h0000, fault_line}, 16'h0000, "thermal under disable");
    check(chan_out, 16'h0000, "disable forces off");
    cooled = 1'b1;
    wait_fault(1'b1, 12);
    cooled = 1'b0;
    enable_n = 1'b0;
    step(4);
  endtask

  // open lamp on channel zero only counts while that channel is on
  task automatic test_open();
    chan_low = 16'h0001;
    m.send(1'b1, 16'h0002, 16);
    m.strobe();
    step(12);
    check({15'h0000, fault_line}, 16'h0001, "off channel ignored");
    m.send(1'b1, 16'h0001, 16);
    fork
      m.strobe();
      begin
        for (int i = 0; i < 30 && chan_out[0] !== 1'b1; i++) step(1);
        check({15'h0000, chan_out[0]}, 16'h0001, "open channel on");
        // two cycles on is too early for a settled detection
        step(2);
        check({15'h0000, fault_line}, 16'h0001, "detection delay");
      end
    join
    wait_fault(1'b0, 8);
    enable_n = 1'b1;
    wait_fault(1'b1, 12);
    enable_n = 1'b0;
    chan_low = 16'h0000;
    step(4);
  endtask

  // row check through a two-device chain, then one lit channel walked to the open lamp
  task automatic test_walk();
    chan_low = 16'h0010;
    enable_n = 1'b1;
    m.send(1'b1, 16'hffff, 16);
    m.send(1'b1, 16'hffff, 16);
    check({15'h0000, serial_out}, 16'h0001, "ones passed to next device");
    m.strobe();
    check(chan_out, 16'h0000, "row held off while disabled");
    enable_n = 1'b0;
    step(8);
    check(chan_out, 16'hffff, "row all on");
    wait_fault(1'b0, 8);
    m.send(1'b1, 16'h0000, 16);
    m.send(1'b1, 16'h0000, 16);
    m.strobe();
    check(chan_out, 16'h0000, "row cleared");
    wait_fault(1'b1, 8);
    // past bit 15 the one has left for the next device
    for (int i = 0; i < 32; i++) begin
      m.send(1'b1, (i == 0) ? 16'h0001 : 16'h0000, 1);
      m.strobe();
      check(chan_out, 16'h0001 << i, "walked channel");
      check({15'h0000, fault_line}, {15'h0000, i != 4}, "walk fault");
    end
    chan_low = 16'h0000;
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    num_errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    edge_sel = 1'b0;
    enable_n = 1'b0;
    overtemp = 1'b0;
    cooled = 1'b0;
    chan_low = 16'h0000;
    step(5);
    reset_n = 1'b1;
    step(8);
    test_reset();
    test_code_and_chan();
    test_sout(1'b1, 1'b1, 1'b0);
    test_sout(1'b0, 1'b1, 1'b1);
    test_thermal();
    test_open();
    test_walk();
    check({15'h0000, overrun}, 16'h0000, "no stream loss at legal rate");
    tally_and_finish();
  end
endmodule
`default_nettype wire
